// file: bench/tmr_pin_src.sv
`timescale 1ns/100ps
module tmr_pin_src (
  // clock
  input wire logic  clk,
  // pins
  output logic [1:0] capture_pin,
  output logic       ext_clock_pin
);
  initial begin
    capture_pin = 2'b00;
    ext_clock_pin = 1'b0;
  end
  // each level held four clocks, so active edges stay far apart
  task automatic ext_set(input logic v);
    ext_clock_pin <= v;
    repeat (4) @(posedge clk);
  endtask
  task automatic ext_pulse(input int n);
    repeat (n) begin
      ext_set(1'b1);
      ext_set(1'b0);
    end
  endtask
  task automatic cap_set(input int ch, input logic v);
    capture_pin[ch] <= v;
    repeat (4) @(posedge clk);
  endtask
endmodule // tmr_pin_src

// file: bench/tmr_timer_sva.sv
`timescale 1ns/100ps
module tmr_timer_sva (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  nrst,
  // register port
  input wire tmr_pkg::tmr_bus_req_t bus_req,
  input wire logic [7:0]            rdata_reg,
  // cpu state
  input wire logic                  halt_mode,
  input wire logic                  cpu_irq_mask,
  input wire logic                  irq_reg,
  // timer pins
  input wire logic [1:0]            capture_pin,
  input wire logic                  ext_clock_pin,
  input wire logic [1:0]            compare_pin_reg,
  input wire logic [1:0]            compare_oe_reg
);
  wire logic rd_st  = bus_req.rd && bus_req.addr == tmr_pkg::OFS_STATUS;
  wire logic rd_lo  = bus_req.rd && bus_req.addr == tmr_pkg::OFS_CNT_LO;
  wire logic rd_alo = bus_req.rd && bus_req.addr == tmr_pkg::OFS_ALT_LO;
  wire logic rd_hi  = bus_req.rd && (bus_req.addr == tmr_pkg::OFS_CNT_HI ||
                                     bus_req.addr == tmr_pkg::OFS_ALT_HI);
  wire logic wr_lo  = bus_req.wr && (bus_req.addr == tmr_pkg::OFS_CNT_LO ||
                                     bus_req.addr == tmr_pkg::OFS_ALT_LO);
  wire logic wr_c1l = bus_req.wr && bus_req.addr == tmr_pkg::OFS_CMP1_LO;
  wire logic rd_c1l = bus_req.rd && bus_req.addr == tmr_pkg::OFS_CMP1_LO;
  wire logic wr_c2  = bus_req.wr && bus_req.addr == tmr_pkg::OFS_CTL_TWO;

  ////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_rd_quiet: assert property (!$past(bus_req.rd) |-> rdata_reg == 8'h00)
    else $error("read data not zero outside answer cycle");
  chk_cnt_reload: assert property (wr_lo ##1 rd_hi |=> rdata_reg == 8'hff)
    else $error("low write did not reload counter");
  chk_cmp_back: assert property (wr_c1l ##1 rd_c1l |=> rdata_reg == $past(bus_req.wdata, 2))
    else $error("compare byte not read back");
  chk_halt_hold: assert property ((halt_mode && rd_lo) [*3] |=> rdata_reg == $past(rdata_reg))
    else $error("counter moved in halt");
  chk_alt_keep: assert property (rd_st ##1 (rd_alo && rdata_reg[tmr_pkg::SR_OVF]) ##1 rd_st
    |=> rdata_reg[tmr_pkg::SR_OVF])
    else $error("alternate low read cleared overflow");
  chk_ovf_clear: assert property (rd_st ##1 (rd_lo && rdata_reg[tmr_pkg::SR_OVF]) ##1 rd_st
    |=> !rdata_reg[tmr_pkg::SR_OVF])
    else $error("overflow not cleared");
  chk_irq_mask: assert property (irq_reg |-> !$past(cpu_irq_mask))
    else $error("interrupt raised while masked");
  chk_oe_follow: assert property (wr_c2 |-> ##2 compare_oe_reg ==
    {$past(bus_req.wdata[6], 2), $past(bus_req.wdata[7], 2)})
    else $error("output enable does not follow control");
endmodule // tmr_timer_sva

bind tmr_timer tmr_timer_sva chk_u (
  .clk(clk), .nrst(nrst), .bus_req(bus_req), .rdata_reg(rdata_reg),
  .halt_mode(halt_mode), .cpu_irq_mask(cpu_irq_mask), .irq_reg(irq_reg),
  .capture_pin(capture_pin), .ext_clock_pin(ext_clock_pin),
  .compare_pin_reg(compare_pin_reg), .compare_oe_reg(compare_oe_reg)
);

// file: bench/tmr_timer_tb.sv
`timescale 1ns/100ps
module tmr_timer_tb;
  logic                  clk;
  logic                  nrst;
  tmr_pkg::tmr_bus_req_t req;
  logic [7:0]            rdata;
  logic                  halt;
  logic                  mask;
  logic                  irq;
  logic [1:0]            cpin;
  logic                  ext;
  logic [1:0]            cmp_pin;
  logic [1:0]            cmp_oe;
  logic [7:0]            rv;
  logic [7:0]            v0;
  logic [7:0]            exp_tab [4] = '{8'h10, 8'h20, 8'h08, 8'h00};
  int                    fail_count;
  int                    check_count;

  tmr_timer dut_u (.clk(clk), .nrst(nrst), .bus_req(req), .rdata_reg(rdata),
    .halt_mode(halt), .cpu_irq_mask(mask), .irq_reg(irq), .capture_pin(cpin),
    .ext_clock_pin(ext), .compare_pin_reg(cmp_pin), .compare_oe_reg(cmp_oe));
  tmr_pin_src src_u (.clk(clk), .capture_pin(cpin), .ext_clock_pin(ext));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic cmp8(input logic [7:0] got, input logic [7:0] e);
    check_count++;
    if (got !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, e);
    end
  endtask
  task automatic idle(input int n);
    req <= '0;
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    fork begin #1 rv = rdata; end join_none
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    fork begin #1 cmp8(rdata, e); end join_none
  endtask
  // output check one step after the edge: 0 irq, 1 pins, 2 enables
  task automatic outc(input int s, input logic [7:0] e);
    fork begin #1 cmp8(s == 0 ? {7'h0, irq} : s == 1 ? {6'h0, cmp_pin} : {6'h0, cmp_oe}, e);
    end join_none
  endtask
  task automatic pulses(input int n);
    idle(0);
    src_u.ext_pulse(n);
  endtask
  task automatic capt(input int ch, input logic v);
    idle(0);
    src_u.cap_set(ch, v);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end

  ////////////////////////////////////////
  initial begin
    req = '0; halt = 1'b0; mask = 1'b0; nrst = 1'b0; fail_count = 0; check_count = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc(tmr_pkg::OFS_CMP1_HI, 8'h80); rdc(tmr_pkg::OFS_CMP2_LO, 8'h00);
    rdc(tmr_pkg::OFS_CNT_HI, 8'hff); rd(tmr_pkg::OFS_CNT_LO);
    wr(4'hf, 8'h55); rdc(4'hf, 8'h00); rdc(tmr_pkg::OFS_STATUS, 8'h00);
    wr(tmr_pkg::OFS_CMP1_LO, 8'h5a); rdc(tmr_pkg::OFS_CMP1_LO, 8'h5a);
    wr(tmr_pkg::OFS_CAP2_HI, 8'h33); rdc(tmr_pkg::OFS_CAP2_HI, 8'h00);
    rdc(tmr_pkg::OFS_CAP2_LO, 8'h00); $display("reset and access test done");
    wr(tmr_pkg::OFS_CTL_TWO, 8'h0d); wr(tmr_pkg::OFS_CNT_LO, 8'h00);
    rdc(tmr_pkg::OFS_CNT_HI, 8'hff); rdc(tmr_pkg::OFS_CNT_LO, 8'hfc);
    pulses(3); rdc(tmr_pkg::OFS_STATUS, 8'h00); rdc(tmr_pkg::OFS_ALT_LO, 8'hff);
    pulses(1); rdc(tmr_pkg::OFS_STATUS, 8'h20); rdc(tmr_pkg::OFS_ALT_HI, 8'h00);
    rdc(tmr_pkg::OFS_ALT_LO, 8'h00); idle(1); outc(0, 8'h00);
    wr(tmr_pkg::OFS_CTL_ONE, 8'h20); idle(2); outc(0, 8'h01);
    mask <= 1'b1; idle(2); outc(0, 8'h00); mask <= 1'b0; idle(2); outc(0, 8'h01);
    rdc(tmr_pkg::OFS_STATUS, 8'h20); rdc(tmr_pkg::OFS_ALT_LO, 8'h00);
    rdc(tmr_pkg::OFS_STATUS, 8'h20); rdc(tmr_pkg::OFS_CNT_LO, 8'h00);
    rdc(tmr_pkg::OFS_STATUS, 8'h00); idle(2); outc(0, 8'h00);
    rdc(tmr_pkg::OFS_CNT_HI, 8'h00); pulses(2); rdc(tmr_pkg::OFS_CNT_HI, 8'h00);
    rdc(tmr_pkg::OFS_ALT_LO, 8'h02); rdc(tmr_pkg::OFS_CNT_LO, 8'h00);
    rdc(tmr_pkg::OFS_CNT_LO, 8'h02);
    wr(tmr_pkg::OFS_CTL_TWO, 8'h0c); idle(0); src_u.ext_set(1'b1);
    rdc(tmr_pkg::OFS_ALT_LO, 8'h02); idle(0); src_u.ext_set(1'b0);
    rdc(tmr_pkg::OFS_ALT_LO, 8'h03); wr(tmr_pkg::OFS_ALT_LO, 8'h00);
    rdc(tmr_pkg::OFS_ALT_HI, 8'hff); rdc(tmr_pkg::OFS_ALT_LO, 8'hfc);
    idle(1); $display("counter test done");
    wr(tmr_pkg::OFS_CTL_TWO, 8'h0d); wr(tmr_pkg::OFS_CTL_ONE, 8'h90); capt(0, 1'b1);
    rdc(tmr_pkg::OFS_STATUS, 8'h80); idle(1); outc(0, 8'h01);
    pulses(1); capt(0, 1'b0); capt(0, 1'b1); rdc(tmr_pkg::OFS_STATUS, 8'h80);
    rdc(tmr_pkg::OFS_CAP1_LO, 8'hfd); rdc(tmr_pkg::OFS_STATUS, 8'h00);
    rdc(tmr_pkg::OFS_CAP1_HI, 8'hff); pulses(1); capt(0, 1'b0); capt(0, 1'b1);
    rdc(tmr_pkg::OFS_STATUS, 8'h00); rdc(tmr_pkg::OFS_CAP1_LO, 8'hfd);
    wr(tmr_pkg::OFS_CTL_TWO, 8'h2f); capt(0, 1'b0); capt(0, 1'b1); capt(1, 1'b1);
    rdc(tmr_pkg::OFS_STATUS, 8'h10); rdc(tmr_pkg::OFS_CAP2_HI, 8'hff);
    rdc(tmr_pkg::OFS_CAP2_LO, 8'hfe); idle(1); $display("capture test done");
    wr(tmr_pkg::OFS_CMP1_HI, 8'h00); wr(tmr_pkg::OFS_CMP1_LO, 8'h01);
    wr(tmr_pkg::OFS_CTL_ONE, 8'h41); wr(tmr_pkg::OFS_CTL_TWO, 8'h8d);
    pulses(3); outc(1, 8'h00); pulses(1); outc(1, 8'h01); outc(2, 8'h01);
    rdc(tmr_pkg::OFS_STATUS, 8'h60); idle(1); outc(0, 8'h01);
    $display("compare test done");
    for (int i = 0; i < 4; i++) begin
      wr(tmr_pkg::OFS_CTL_TWO, {4'h0, i[1:0], 2'b00});
      rd(tmr_pkg::OFS_ALT_LO); idle(1); v0 = rv; idle(62);
      rd(tmr_pkg::OFS_ALT_LO); idle(1);
      cmp8(rv - v0, exp_tab[i]);
    end
    wr(tmr_pkg::OFS_CTL_TWO, 8'h04); halt <= 1'b1; idle(2);
    rd(tmr_pkg::OFS_ALT_LO); idle(1); v0 = rv; idle(20);
    rdc(tmr_pkg::OFS_CNT_LO, v0); rdc(tmr_pkg::OFS_CNT_LO, v0);
    rdc(tmr_pkg::OFS_CNT_LO, v0); halt <= 1'b0; idle(2);
    $display("prescaler and halt test done");
    test_done();
  end
endmodule // tmr_timer_tb

// file: common/tmr_pkg.sv
package tmr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // register byte offsets
  localparam logic [3:0] OFS_CTL_ONE   = 4'h0;
  localparam logic [3:0] OFS_CTL_TWO   = 4'h1;
  localparam logic [3:0] OFS_STATUS    = 4'h2;
  localparam logic [3:0] OFS_CAP1_HI   = 4'h3;
  localparam logic [3:0] OFS_CAP1_LO   = 4'h4;
  localparam logic [3:0] OFS_CMP1_HI   = 4'h5;
  localparam logic [3:0] OFS_CMP1_LO   = 4'h6;
  localparam logic [3:0] OFS_CNT_HI    = 4'h7;
  localparam logic [3:0] OFS_CNT_LO    = 4'h8;
  localparam logic [3:0] OFS_ALT_HI    = 4'h9;
  localparam logic [3:0] OFS_ALT_LO    = 4'ha;
  localparam logic [3:0] OFS_CAP2_HI   = 4'hb;
  localparam logic [3:0] OFS_CAP2_LO   = 4'hc;
  localparam logic [3:0] OFS_CMP2_HI   = 4'hd;
  localparam logic [3:0] OFS_CMP2_LO   = 4'he;

  ////////////////////////////////////////////////////////////////////////////
  // control one bit positions
  localparam int C1_CAP_IE   = 7;
  localparam int C1_CMP_IE   = 6;
  localparam int C1_OVF_IE   = 5;
  localparam int C1_CAP_EDG1 = 4;
  localparam int C1_LVL2     = 1;
  localparam int C1_LVL1     = 0;

  // control two bit positions
  localparam int C2_CMP_OE1  = 7;
  localparam int C2_CMP_OE2  = 6;
  localparam int C2_ONE_PLS  = 5;
  localparam int C2_PWM      = 4;
  localparam int C2_CLK_HI   = 3;
  localparam int C2_CLK_LO   = 2;
  localparam int C2_CAP_EDG2 = 1;
  localparam int C2_EXT_EDG  = 0;

  // status bit positions
  localparam int SR_CAP1 = 7;
  localparam int SR_CMP1 = 6;
  localparam int SR_OVF  = 5;
  localparam int SR_CAP2 = 4;
  localparam int SR_CMP2 = 3;

  ////////////////////////////////////////////////////////////////////////////
  // reset and reload values
  localparam logic [15:0] CNT_RELOAD   = 16'hfffc;
  localparam logic [15:0] CNT_TOP      = 16'hffff;
  localparam logic [15:0] CMP_RESET    = 16'h8000;
  localparam logic [15:0] CAP_RESET    = 16'h0000;
  localparam logic [7:0]  CTL_RESET    = 8'h00;

  // clock select codes
  localparam logic [1:0] CLK_DIV4 = 2'b00;
  localparam logic [1:0] CLK_DIV2 = 2'b01;
  localparam logic [1:0] CLK_DIV8 = 2'b10;
  localparam logic [1:0] CLK_EXT  = 2'b11;

  ////////////////////////////////////////////////////////////////////////////
  // register port request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } tmr_bus_req_t;

  // capture channel status carried to the top
  typedef struct packed {
    logic        flag;
    logic [15:0] value;
  } tmr_cap_t;

endpackage

// file: rtl/tmr_cap_chan.sv
`timescale 1ns/100ps
module tmr_cap_chan (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            nrst,
  // pin side
  input  wire logic            pin,
  input  wire logic            edge_sel,
  input  wire logic            enable,
  input  wire logic [15:0]     count,
  // register side
  input  wire logic            status_rd,
  input  wire logic            high_rd,
  input  wire logic            low_rd,
  input  wire logic            low_access,
  // result
  output tmr_pkg::tmr_cap_t    cap_reg
);

  logic pin_prev_reg;
  logic inhibit_reg;
  logic arm_reg;
  logic hit;

  // active transition: rising when edge_sel is one
  assign hit = enable & ~inhibit_reg & (edge_sel ? (pin & ~pin_prev_reg)
                                                 : (~pin & pin_prev_reg));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin;
    end
  end

  // high byte read blocks capture until low byte read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      inhibit_reg <= 1'b0;
    end else if (low_rd) begin
      inhibit_reg <= 1'b0;
    end else if (high_rd) begin
      inhibit_reg <= 1'b1;
    end
  end

  // latest capture always overwrites
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cap_reg.value <= tmr_pkg::CAP_RESET;
    end else if (hit) begin
      cap_reg.value <= count;
    end
  end

  // flag: set wins over the two-step clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cap_reg.flag <= 1'b0;
      arm_reg      <= 1'b0;
    end else begin
      if (hit) begin
        cap_reg.flag <= 1'b1;
      end else if (arm_reg && low_access) begin
        cap_reg.flag <= 1'b0;
      end
      if (low_access) begin
        arm_reg <= 1'b0;
      end else if (status_rd && cap_reg.flag) begin
        arm_reg <= 1'b1;
      end
    end
  end

endmodule // tmr_cap_chan

// file: rtl/tmr_timer.sv
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
// What this block does
// - free 16-bit up-counter, primary and alternate pairs
// - alternate low read never clears overflow
// - low write reloads FFFCh, also reset value
// - count at cpu/2, /4, /8 or external
// - external source only when both select bits
// - edge bit picks external active transition
// - high read freezes low byte until low read
// - lone low read returns live count
// - wrap FFFFh to 0000h sets overflow flag
// - overflow irq needs enable and mask clear
// - overflow clear: status read then low access
// - counts in wait, holds in halt
// - capture edge copies counter, sets flag
// - shared capture enable, pending until unmasked
// - capture clear: status read then low access
// - capture high read blocks capture till low
// - latest capture overwrites unread value
// - pulse or pwm mode: only capture two
// - capture pin two always feeds capture logic
// - compare every timer clock, flag, pin, irq
// - compare registers software only, reset 8000h
module tmr_timer (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       nrst,
  // register port
  input  tmr_pkg::tmr_bus_req_t           bus_req,
  output logic [tmr_pkg::DATA_W-1:0]      rdata_reg,
  // cpu state
  input  wire logic                       halt_mode,
  input  wire logic                       cpu_irq_mask,
  output logic                            irq_reg,
  // timer pins
  input  wire logic [1:0]                 capture_pin,
  input  wire logic                       ext_clock_pin,
  output logic [1:0]                      compare_pin_reg,
  output logic [1:0]                      compare_oe_reg
);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0]  timer_control_one;
  logic [7:0]  timer_control_two;
  logic [15:0] count_value;
  logic [15:0] compare_value_one;
  logic [15:0] compare_value_two;
  logic [7:0]  cnt_low_buf;
  logic        cnt_latched;
  logic [7:0]  alt_low_buf;
  logic        alt_latched;
  logic        overflow_flag;
  logic        ovf_arm;
  logic [1:0]  compare_flag;
  logic [1:0]  cmp_arm;
  logic [2:0]  prescale_reg;
  logic        ext_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic        rd_status;
  logic        rd_cnt_hi;
  logic        rd_cnt_lo;
  logic        wr_cnt_lo;
  logic        rd_alt_hi;
  logic        rd_alt_lo;
  logic        wr_alt_lo;
  logic        acc_cmp1_lo;
  logic        acc_cmp2_lo;
  logic [7:0]  rd_val;

  assign rd_status   = bus_req.rd && (bus_req.addr == tmr_pkg::OFS_STATUS);
  assign rd_cnt_hi   = bus_req.rd && (bus_req.addr == tmr_pkg::OFS_CNT_HI);
  assign rd_cnt_lo   = bus_req.rd && (bus_req.addr == tmr_pkg::OFS_CNT_LO);
  assign wr_cnt_lo   = bus_req.wr && (bus_req.addr == tmr_pkg::OFS_CNT_LO);
  assign rd_alt_hi   = bus_req.rd && (bus_req.addr == tmr_pkg::OFS_ALT_HI);
  assign rd_alt_lo   = bus_req.rd && (bus_req.addr == tmr_pkg::OFS_ALT_LO);
  assign wr_alt_lo   = bus_req.wr && (bus_req.addr == tmr_pkg::OFS_ALT_LO);
  assign acc_cmp1_lo = (bus_req.rd || bus_req.wr) && (bus_req.addr == tmr_pkg::OFS_CMP1_LO);
  assign acc_cmp2_lo = (bus_req.rd || bus_req.wr) && (bus_req.addr == tmr_pkg::OFS_CMP2_LO);

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_control_one <= tmr_pkg::CTL_RESET;
      timer_control_two <= tmr_pkg::CTL_RESET;
    end else if (bus_req.wr) begin
      if (bus_req.addr == tmr_pkg::OFS_CTL_ONE) begin
        timer_control_one <= bus_req.wdata;
      end
      if (bus_req.addr == tmr_pkg::OFS_CTL_TWO) begin
        timer_control_two <= bus_req.wdata;
      end
    end
  end

  logic [1:0] clock_select_field;
  logic       ext_clock_edge_select;
  logic       waveform_mode;

  assign clock_select_field    = {timer_control_two[tmr_pkg::C2_CLK_HI],
                                  timer_control_two[tmr_pkg::C2_CLK_LO]};
  assign ext_clock_edge_select = timer_control_two[tmr_pkg::C2_EXT_EDG];
  assign waveform_mode         = timer_control_two[tmr_pkg::C2_ONE_PLS] |
                                 timer_control_two[tmr_pkg::C2_PWM];

  ////////////////////////////////////////////////////////////////////////////
  // timer clock: prescaler or external edge
  logic prescale_hit;
  logic ext_edge;
  logic tick;

  // prescaler freezes with the counter in halt
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prescale_reg <= 3'h0;
    end else if (!halt_mode) begin
      prescale_reg <= prescale_reg + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_clock_pin;
    end
  end

  always_comb begin
    prescale_hit = 1'b0;
    case (clock_select_field)
      tmr_pkg::CLK_DIV4: prescale_hit = (prescale_reg[1:0] == 2'b11);
      tmr_pkg::CLK_DIV2: prescale_hit = prescale_reg[0];
      tmr_pkg::CLK_DIV8: prescale_hit = (prescale_reg == 3'b111);
      default:           prescale_hit = 1'b0;
    endcase
  end

  // one edge of clk per active external transition; spacing relied on
  assign ext_edge = ext_clock_edge_select ? (ext_clock_pin & ~ext_prev_reg)
                                          : (~ext_clock_pin & ext_prev_reg);

  assign tick = ~halt_mode & ((clock_select_field == tmr_pkg::CLK_EXT) ? ext_edge
                                                                       : prescale_hit);

  ////////////////////////////////////////////////////////////////////////////
  // free running counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_value <= tmr_pkg::CNT_RELOAD;
    end else if (wr_cnt_lo || wr_alt_lo) begin
      count_value <= tmr_pkg::CNT_RELOAD;
    end else if (tick) begin
      count_value <= count_value + 16'h0001;
    end
  end

  // low byte buffers of the two read pairs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_low_buf <= 8'h00;
      cnt_latched <= 1'b0;
    end else if (rd_cnt_lo) begin
      cnt_latched <= 1'b0;
    end else if (rd_cnt_hi && !cnt_latched) begin
      cnt_low_buf <= count_value[7:0];
      cnt_latched <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alt_low_buf <= 8'h00;
      alt_latched <= 1'b0;
    end else if (rd_alt_lo) begin
      alt_latched <= 1'b0;
    end else if (rd_alt_hi && !alt_latched) begin
      alt_low_buf <= count_value[7:0];
      alt_latched <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overflow flag: only the primary low byte completes the clear
  logic wrap;

  assign wrap = tick && (count_value == tmr_pkg::CNT_TOP) && !(wr_cnt_lo || wr_alt_lo);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      overflow_flag <= 1'b0;
      ovf_arm       <= 1'b0;
    end else begin
      if (wrap) begin
        overflow_flag <= 1'b1;
      end else if (ovf_arm && (rd_cnt_lo || wr_cnt_lo)) begin
        overflow_flag <= 1'b0;
      end
      if (rd_cnt_lo || wr_cnt_lo) begin
        ovf_arm <= 1'b0;
      end else if (rd_status && overflow_flag) begin
        ovf_arm <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture channels; channel one is off in waveform modes
  tmr_pkg::tmr_cap_t cap_one;
  tmr_pkg::tmr_cap_t cap_two;

  tmr_cap_chan u_cap_one (
    .clk        (clk),
    .nrst       (nrst),
    .pin        (capture_pin[0]),
    .edge_sel   (timer_control_one[tmr_pkg::C1_CAP_EDG1]),
    .enable     (~waveform_mode),
    .count      (count_value),
    .status_rd  (rd_status),
    .high_rd    (bus_req.rd && (bus_req.addr == tmr_pkg::OFS_CAP1_HI)),
    .low_rd     (bus_req.rd && (bus_req.addr == tmr_pkg::OFS_CAP1_LO)),
    .low_access ((bus_req.rd || bus_req.wr) && (bus_req.addr == tmr_pkg::OFS_CAP1_LO)),
    .cap_reg    (cap_one)
  );

  tmr_cap_chan u_cap_two (
    .clk        (clk),
    .nrst       (nrst),
    .pin        (capture_pin[1]),
    .edge_sel   (timer_control_two[tmr_pkg::C2_CAP_EDG2]),
    .enable     (1'b1),
    .count      (count_value),
    .status_rd  (rd_status),
    .high_rd    (bus_req.rd && (bus_req.addr == tmr_pkg::OFS_CAP2_HI)),
    .low_rd     (bus_req.rd && (bus_req.addr == tmr_pkg::OFS_CAP2_LO)),
    .low_access ((bus_req.rd || bus_req.wr) && (bus_req.addr == tmr_pkg::OFS_CAP2_LO)),
    .cap_reg    (cap_two)
  );

  ////////////////////////////////////////////////////////////////////////////
  // compare registers: written only by software
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      compare_value_one <= tmr_pkg::CMP_RESET;
      compare_value_two <= tmr_pkg::CMP_RESET;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        tmr_pkg::OFS_CMP1_HI: compare_value_one[15:8] <= bus_req.wdata;
        tmr_pkg::OFS_CMP1_LO: compare_value_one[7:0]  <= bus_req.wdata;
        tmr_pkg::OFS_CMP2_HI: compare_value_two[15:8] <= bus_req.wdata;
        tmr_pkg::OFS_CMP2_LO: compare_value_two[7:0]  <= bus_req.wdata;
        default: ;
      endcase
    end
  end

  logic [1:0] match;
  logic [1:0] cmp_access;
  logic [1:0] cmp_level;

  assign match[0]   = tick && (count_value == compare_value_one);
  assign match[1]   = tick && (count_value == compare_value_two);
  assign cmp_access = {acc_cmp2_lo, acc_cmp1_lo};
  assign cmp_level  = {timer_control_one[tmr_pkg::C1_LVL2], timer_control_one[tmr_pkg::C1_LVL1]};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      compare_flag <= 2'b00;
      cmp_arm      <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (match[i]) begin
          compare_flag[i] <= 1'b1;
        end else if (cmp_arm[i] && cmp_access[i]) begin
          compare_flag[i] <= 1'b0;
        end
        if (cmp_access[i]) begin
          cmp_arm[i] <= 1'b0;
        end else if (rd_status && compare_flag[i]) begin
          cmp_arm[i] <= 1'b1;
        end
      end
    end
  end

  // pin latch is low in reset, takes the level on a match
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      compare_pin_reg <= 2'b00;
      compare_oe_reg  <= 2'b00;
    end else begin
      compare_oe_reg <= {timer_control_two[tmr_pkg::C2_CMP_OE2],
                         timer_control_two[tmr_pkg::C2_CMP_OE1]};
      for (int i = 0; i < 2; i++) begin
        if (match[i]) begin
          compare_pin_reg[i] <= cmp_level[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt request, held while flags stay pending
  logic irq_next;

  always_comb begin
    irq_next = 1'b0;
    if (!cpu_irq_mask) begin
      irq_next = (overflow_flag & timer_control_one[tmr_pkg::C1_OVF_IE])
               | ((cap_one.flag | cap_two.flag) & timer_control_one[tmr_pkg::C1_CAP_IE])
               | ((compare_flag[0] | compare_flag[1])
                  & timer_control_one[tmr_pkg::C1_CMP_IE]);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe
  always_comb begin
    rd_val = 8'h00;
    case (bus_req.addr)
      tmr_pkg::OFS_CTL_ONE: rd_val = timer_control_one;
      tmr_pkg::OFS_CTL_TWO: rd_val = timer_control_two;
      tmr_pkg::OFS_STATUS: begin
        rd_val[tmr_pkg::SR_CAP1] = cap_one.flag;
        rd_val[tmr_pkg::SR_CMP1] = compare_flag[0];
        rd_val[tmr_pkg::SR_OVF]  = overflow_flag;
        rd_val[tmr_pkg::SR_CAP2] = cap_two.flag;
        rd_val[tmr_pkg::SR_CMP2] = compare_flag[1];
      end
      tmr_pkg::OFS_CAP1_HI: rd_val = cap_one.value[15:8];
      tmr_pkg::OFS_CAP1_LO: rd_val = cap_one.value[7:0];
      tmr_pkg::OFS_CMP1_HI: rd_val = compare_value_one[15:8];
      tmr_pkg::OFS_CMP1_LO: rd_val = compare_value_one[7:0];
      tmr_pkg::OFS_CNT_HI:  rd_val = count_value[15:8];
      tmr_pkg::OFS_CNT_LO:  rd_val = cnt_latched ? cnt_low_buf : count_value[7:0];
      tmr_pkg::OFS_ALT_HI:  rd_val = count_value[15:8];
      tmr_pkg::OFS_ALT_LO:  rd_val = alt_latched ? alt_low_buf : count_value[7:0];
      tmr_pkg::OFS_CAP2_HI: rd_val = cap_two.value[15:8];
      tmr_pkg::OFS_CAP2_LO: rd_val = cap_two.value[7:0];
      tmr_pkg::OFS_CMP2_HI: rd_val = compare_value_two[15:8];
      tmr_pkg::OFS_CMP2_LO: rd_val = compare_value_two[7:0];
      default:              rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else if (bus_req.rd) begin
      rdata_reg <= rd_val;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

endmodule // tmr_timer
